// *** hdl/port_a_pkg.sv ***
// Shared constants for the six-pin port A control block
package port_a_pkg;
    localparam int unsigned PIN_COUNT_DEF  = 6;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned ADDR_W         = 4;

    // Register offsets on the plain register port
    localparam logic [3:0]  OFS_PIN_LEVEL  = 4'h0;
    localparam logic [3:0]  OFS_DIRECTION  = 4'h1;
    localparam logic [3:0]  OFS_LATCH      = 4'h2;
    localparam logic [3:0]  OFS_ANALOG     = 4'h3;
    localparam logic [3:0]  OFS_PULLUP     = 4'h4;

    // Field positions and masks
    localparam int unsigned INPUT_ONLY_BIT = 3;
    localparam logic [5:0]  IMPL_MASK      = 6'h37;
    localparam logic [5:0]  PULLUP_MASK    = 6'h3F;
    localparam logic [5:0]  INPUT_ONLY_MASK = 6'h08;

    // Reset values
    localparam logic [5:0]  DIRECTION_RST  = 6'h37;
    localparam logic [5:0]  ANALOG_RST     = 6'h37;
    localparam logic [5:0]  PULLUP_RST     = 6'h00;
    localparam logic [5:0]  LATCH_POR_RST  = 6'h00;
    localparam logic [7:0]  READ_IDLE      = 8'h00;

    // Synchroniser depth
    localparam int unsigned SYNC_STAGES    = 2;
endpackage

// *** hdl/pin_ctrl_if.sv ***
// Carrier for the pad control settings between the register block and pad drive
interface pin_ctrl_if;
    logic [5:0] latch;
    logic [5:0] direction;
    logic [5:0] pullup_enable_bits;
    logic [5:0] analog_select_bits;
    logic       ext_reset_enable;

    modport src (output latch, output direction, output pullup_enable_bits,
                 output analog_select_bits, output ext_reset_enable);
    modport dst (input latch, input direction, input pullup_enable_bits,
                 input analog_select_bits, input ext_reset_enable);
endinterface

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pad levels
module pin_sync
    import port_a_pkg::*;
#(
    parameter int unsigned WIDTH = PIN_COUNT_DEF
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // Refused at elaboration, before any logic is built
    if (WIDTH < 1)
    begin
        $error("pin_sync needs at least one bit");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// *** hdl/pad_drive.sv ***
// Registered pad driver: output value, output enable, weak pull-ups, analog select
module pad_drive
    import port_a_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    pin_ctrl_if.dst         ctrl,
    output logic [5:0]      pad_out,
    output logic [5:0]      pad_oe,
    output logic [5:0]      pullup_on,
    output logic [5:0]      analog_on
);
    wire [5:0] oe_nxt;
    wire [5:0] pullup_nxt;

    // Driver follows the direction bit, pin three held off; analog select leaves it alone
    assign oe_nxt = ~ctrl.direction & ~INPUT_ONLY_MASK; // [R2] [R12]

    // Pull-up dropped on any output pin; pin three forced on by external reset
    assign pullup_nxt = (ctrl.pullup_enable_bits & ctrl.direction & ~INPUT_ONLY_MASK) // [R6] [R16]
                      | ({2'h0, ctrl.ext_reset_enable | ctrl.pullup_enable_bits[INPUT_ONLY_BIT],
                          3'h0}); // [R7]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_out   <= LATCH_POR_RST;
            pad_oe    <= '0;
            pullup_on <= PULLUP_RST;
            analog_on <= ANALOG_RST;
        end
        else
        begin
            pad_out   <= ctrl.latch & IMPL_MASK; // [R8]
            pad_oe    <= oe_nxt;
            pullup_on <= pullup_nxt;
            analog_on <= ctrl.analog_select_bits;
        end
    end
endmodule

// *** hdl/port_a_ctrl.sv ***
// Port A control block: registers, digital read path and pad control
//
// What this block does
// [R1] Analog-selected pins read zero on every digital read path.
// [R2] Analog select never changes the digital output driver or value.
// [R3] Writes to pin level take the zeroed analog reads as written; no fix-up.
// [R4] Every reset puts all analog-select bits into analog mode.
// [R5] Software clears analog select on pins it uses as digital inputs.
// [R6] Each pin has an independent weak pull-up enable bit.
// [R7] Pin three pull-up is on if external reset enabled or its bit set; held off while rst_n is low.
// [R8] After reset each pin output comes from the output latch.
// [R9] Pin level register returns pin levels on bits 5-0, zero above.
// [R10] Pin level writes update the latch; pin level reads return pins.
// [R11] Pin three level bit is read-only, reads one with external reset on.
// [R12] Direction one means input driver off; zero means output; reset one.
// [R13] Direction bit three always reads one; bits 7 and 6 read zero.
// [R14] Latch holds bits 5-4 and 2-0; bits 3, 7, 6 read zero.
// [R15] Analog bits on pins 5, 4, 2-0, reset to one, disable input.
// [R16] Pull-up switched off whenever the pin is an output.
// [R17] Pin levels pass a two-stage synchroniser before being read.
// [R18] Latch keeps its value through all resets but power-on reset.
//
// Implementation choices: the strobed register port and the address map.
module port_a_ctrl
    import port_a_pkg::*;
#(
    parameter int unsigned PIN_COUNT = PIN_COUNT_DEF
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sys_reset,
    input  wire logic              ext_reset_enable,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid,
    input  wire logic [5:0]        pad_in,
    output logic      [5:0]        pad_out,
    output logic      [5:0]        pad_oe,
    output logic      [5:0]        pullup_on,
    output logic      [5:0]        analog_on,
    output logic      [5:0]        port_pin_values
);
    // Only the six-pin arrangement is built; refused at elaboration
    if (PIN_COUNT != PIN_COUNT_DEF)
    begin
        $error("port_a_ctrl supports exactly six pins");
    end

    // Keep only the bits that have storage behind them
    function automatic logic [5:0] keep_impl(input logic [5:0] value);
        keep_impl = value & IMPL_MASK;
    endfunction

    // Widen a six-bit field onto the data bus, upper bits zero
    function automatic logic [DATA_W-1:0] to_bus(input logic [5:0] value);
        to_bus = {2'b00, value};
    endfunction

    // Stored state
    logic [5:0] latch_r;
    logic [5:0] latch_nxt;
    logic [5:0] direction_r;
    logic [5:0] direction_nxt;
    logic [5:0] analog_r;
    logic [5:0] analog_nxt;
    logic [5:0] pullup_r;
    logic [5:0] pullup_nxt;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [5:0] pin_values_nxt;

    // Synchronised pad levels
    wire [5:0] pad_sync;

    // Pads are asynchronous; two flops before any read logic
    pin_sync #(
        .WIDTH    (6)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pad_in),
        .sync_out (pad_sync) // [R17]
    );

    // Address decode
    wire sel_level     = (addr == OFS_PIN_LEVEL);
    wire sel_direction = (addr == OFS_DIRECTION);
    wire sel_latch     = (addr == OFS_LATCH);
    wire sel_analog    = (addr == OFS_ANALOG);
    wire sel_pullup    = (addr == OFS_PULLUP);

    wire wr_level      = wr_stb & sel_level;
    wire wr_direction  = wr_stb & sel_direction;
    wire wr_latch      = wr_stb & sel_latch;
    wire wr_analog     = wr_stb & sel_analog;
    wire wr_pullup     = wr_stb & sel_pullup;

    // Digital input buffer off on analog pins, so reads see zero
    wire [5:0] digital_in = pad_sync & ~analog_r; // [R1] [R15]

    // Pin three has no analog bit; external reset pins its reading high
    wire pin3_level = ext_reset_enable | pad_sync[INPUT_ONLY_BIT]; // [R11]

    // Pin level value as software and peripherals see it
    wire [5:0] level_view = {digital_in[5:4], pin3_level, digital_in[2:0]}; // [R9]

    // Direction reads with the input-only bit forced high
    wire [5:0] direction_view = direction_r | INPUT_ONLY_MASK; // [R13]

    // Write to pin level or to latch lands in the latch alike
    // Writes carry whatever software read back, so analog pins may be zeroed
    assign latch_nxt = (wr_level | wr_latch) ? keep_impl(wr_data[5:0]) : latch_r; // [R3] [R10] [R14]

    // Direction bits writable except the input-only pin
    assign direction_nxt = wr_direction ? keep_impl(wr_data[5:0]) : direction_r; // [R12]

    // Analog select on implemented pins only
    assign analog_nxt = wr_analog ? keep_impl(wr_data[5:0]) : analog_r; // [R15]

    // Each pull-up bit stored on its own, pin three included
    assign pullup_nxt = wr_pullup ? (wr_data[5:0] & PULLUP_MASK) : pullup_r; // [R6]

    // Read multiplexer; unmapped offsets answer zero
    always_comb
    begin
        rd_data_nxt = READ_IDLE;
        if (rd_stb)
        begin
            case (addr)
                OFS_PIN_LEVEL: rd_data_nxt = to_bus(level_view); // [R10]
                OFS_DIRECTION: rd_data_nxt = to_bus(direction_view);
                OFS_LATCH:     rd_data_nxt = to_bus(latch_r); // [R14]
                OFS_ANALOG:    rd_data_nxt = to_bus(analog_r);
                OFS_PULLUP:    rd_data_nxt = to_bus(pullup_r);
                default:       rd_data_nxt = READ_IDLE;
            endcase
        end
    end

    // Peripheral inputs get the same gated view as software
    assign pin_values_nxt = level_view; // [R1]

    // Latch survives device resets; only power-on clears it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            latch_r <= LATCH_POR_RST; // [R18]
        else
            latch_r <= latch_nxt;
    end

    // Configuration registers return to defaults on any reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            direction_r <= DIRECTION_RST; // [R12]
            analog_r    <= ANALOG_RST; // [R4]
            pullup_r    <= PULLUP_RST;
        end
        else if (sys_reset)
        begin
            direction_r <= DIRECTION_RST;
            analog_r    <= ANALOG_RST; // [R4]
            pullup_r    <= PULLUP_RST;
        end
        else
        begin
            direction_r <= direction_nxt;
            analog_r    <= analog_nxt;
            pullup_r    <= pullup_nxt;
        end
    end

    // Read answer stands one cycle only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data         <= READ_IDLE;
            rd_valid        <= 1'b0;
            port_pin_values <= '0;
        end
        else
        begin
            rd_data         <= rd_data_nxt;
            rd_valid        <= rd_stb;
            port_pin_values <= pin_values_nxt;
        end
    end

    // Settings handed to the pad driver
    pin_ctrl_if u_ctrl ();

    assign u_ctrl.latch              = latch_r; // [R8]
    assign u_ctrl.direction          = direction_r;
    assign u_ctrl.pullup_enable_bits = pullup_r;
    assign u_ctrl.analog_select_bits = analog_r;
    assign u_ctrl.ext_reset_enable   = ext_reset_enable;

    // Output path is registered once more so ports come from flops
    pad_drive u_drive (
        .clk       (clk),
        .rst_n     (rst_n),
        .ctrl      (u_ctrl.dst),
        .pad_out   (pad_out),
        .pad_oe    (pad_oe), // [R2]
        .pullup_on (pullup_on), // [R7] [R16]
        .analog_on (analog_on)
    );
endmodule

// *** sim/port_a_checker.sv ***
// Port-level checker for the port A control block
module port_a_checker
    import port_a_pkg::*;
#(
    parameter int unsigned PIN_COUNT = PIN_COUNT_DEF
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              sys_reset,
    input wire logic              ext_reset_enable,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              rd_valid,
    input wire logic [5:0]        pad_in,
    input wire logic [5:0]        pad_out,
    input wire logic [5:0]        pad_oe,
    input wire logic [5:0]        pullup_on,
    input wire logic [5:0]        analog_on,
    input wire logic [5:0]        port_pin_values
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Writes landing in the latch, by either offset
    sequence s_lat_wr;
        wr_stb && (addr == OFS_LATCH || addr == OFS_PIN_LEVEL);
    endsequence
    // Direction write with no sync reset in the two cycles it needs
    sequence s_dir_wr;
        wr_stb && !sys_reset && addr == OFS_DIRECTION ##1 !sys_reset;
    endsequence
    chk_read_answer: assert property (rd_valid == $past(rd_stb))
        else $error("read answer not one cycle after strobe");
    chk_read_idle: assert property (!rd_valid |-> rd_data == 8'h00)
        else $error("read data not zero outside answer");
    chk_upper_zero: assert property (rd_data[7:6] == 2'b00)
        else $error("read data bits 7 and 6 not zero");
    chk_dir_bit3: assert property (rd_stb && addr == OFS_DIRECTION |=> rd_data[3])
        else $error("direction bit 3 read as zero");
    chk_pin3_ext: assert property (
        rd_stb && addr == OFS_PIN_LEVEL && ext_reset_enable |=> rd_data[3])
        else $error("pin three level not one with external reset on");
    chk_level_view: assert property (
        rd_stb && addr == OFS_PIN_LEVEL
        |=> (rd_data[5:0] & 6'h37) == (port_pin_values & 6'h37))
        else $error("pin level read differs from digital view");
    chk_analog_zero: assert property ((port_pin_values & analog_on & 6'h37) == 6'h00)
        else $error("analog pin reads nonzero");
    chk_pull3_ext: assert property (ext_reset_enable |=> pullup_on[3])
        else $error("pin three pull-up off with external reset on");
    chk_pull_out: assert property ((pullup_on & pad_oe) == 6'h00)
        else $error("pull-up on while driving");
    chk_latch_pad: assert property (
        s_lat_wr |-> ##2 pad_out == ($past(wr_data[5:0], 2) & 6'h37))
        else $error("pad output not the written latch");
    chk_dir_pad: assert property (
        s_dir_wr |-> ##1 pad_oe == (~$past(wr_data[5:0], 2) & 6'h37))
        else $error("pad enable not the inverse direction");
    // Two sync flops plus the output flop: digital pins lag the pads by three edges
    chk_sync_depth: assert property (
        (port_pin_values & ~analog_on & 6'h37) == ($past(pad_in, 3) & ~analog_on & 6'h37))
        else $error("pin level not three cycles behind pad");
endmodule

bind port_a_ctrl port_a_checker #(
    .PIN_COUNT        (PIN_COUNT)
) port_a_checker_inst (
    .clk              (clk),
    .rst_n            (rst_n),
    .sys_reset        (sys_reset),
    .ext_reset_enable (ext_reset_enable),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_stb           (wr_stb),
    .rd_stb           (rd_stb),
    .rd_data          (rd_data),
    .rd_valid         (rd_valid),
    .pad_in           (pad_in),
    .pad_out          (pad_out),
    .pad_oe           (pad_oe),
    .pullup_on        (pullup_on),
    .analog_on        (analog_on),
    .port_pin_values  (port_pin_values)
);

// *** sim/port_a_ctrl_tb.sv ***
// Self-checking bench for the port A control block
module port_a_ctrl_tb
    import port_a_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic RD = 1'b0;
    localparam logic WR = 1'b1;
    logic              clk, rst_n, sys_reset, ext_reset_enable, wr_stb, rd_stb, rd_valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [5:0]        pad_in, pad_out, pad_oe, pullup_on, analog_on, port_pin_values, d;
    logic [7:0]        q[$];
    int                n_mismatch, samples_checked, seed;

    port_a_ctrl port_a_ctrl_inst (.clk(clk), .rst_n(rst_n), .sys_reset(sys_reset),
        .ext_reset_enable(ext_reset_enable), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on),
        .analog_on(analog_on), .port_pin_values(port_pin_values));

    // Free-running 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // One bus cycle; a read notes its expected answer
    task automatic bus(input logic [ADDR_W-1:0] a, input logic [7:0] v, input logic w);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= w;
        rd_stb <= !w;
        if (!w)
            q.push_back(v);
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    endtask

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Pad-side outputs, looked at once settled
    task automatic cmp_pad(input logic [5:0] g, input logic [5:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t pad got %h expected %h", $time, g, e);
        end
    endtask

    // Registered pad outputs settle one cycle behind
    task automatic st;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up;
        if (q.size() != 0)
            n_mismatch++;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Answer watcher at the falling edge, clear of the edge that launches the answer
    always @(negedge clk)
        if (rd_valid === 1'b1)
            cmp(rd_data, (q.size() > 0) ? q.pop_front() : 8'hXX);

    initial
    begin
        seed = 96719;
        {rst_n, sys_reset, wr_stb, rd_stb} = 4'h0;
        ext_reset_enable = 1'b1;
        addr = 4'h0;
        wr_data = 8'h00;
        pad_in = 6'h3F;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unmapped place
        bus(OFS_PIN_LEVEL, 8'h08, RD);
        bus(OFS_DIRECTION, 8'h3F, RD);
        bus(OFS_LATCH, 8'h00, RD);
        bus(OFS_ANALOG, 8'h37, RD);
        bus(OFS_PULLUP, 8'h00, RD);
        bus(4'h5, 8'h00, RD);
        cmp_pad(pad_oe, 6'h00);
        // Outputs with analog still selected
        d = 6'($random(seed));
        bus(OFS_LATCH, {2'b11, d}, WR);
        bus(OFS_LATCH, {2'b00, d & 6'h37}, RD);
        bus(OFS_DIRECTION, 8'h00, WR);
        bus(OFS_DIRECTION, 8'h08, RD);
        st;
        cmp_pad(pad_out, d & 6'h37);
        cmp_pad(pad_oe, 6'h37);
        // Read-modify-write loses latch bits on analog pins; back on the edge first
        @(posedge clk);
        pad_in <= 6'h3F;
        bus(OFS_PIN_LEVEL, 8'h08, RD);
        bus(OFS_PIN_LEVEL, 8'h08, WR);
        bus(OFS_LATCH, 8'h00, RD);
        st;
        cmp_pad(pad_out, 6'h00);
        // Digital inputs see synchronised pins
        bus(OFS_ANALOG, 8'h00, WR);
        bus(OFS_DIRECTION, 8'hFF, WR);
        d = 6'($random(seed));
        pad_in <= d;
        st;
        cmp_pad(analog_on, 6'h00);
        bus(OFS_PIN_LEVEL, {2'b00, d[5:4], 1'b1, d[2:0]}, RD);
        ext_reset_enable <= 1'b0;
        bus(OFS_PIN_LEVEL, {2'b00, d}, RD);
        bus(OFS_PIN_LEVEL, {2'b11, ~d}, WR);
        bus(OFS_LATCH, {2'b00, ~d & 6'h37}, RD);
        // Pull-ups per pin, off on outputs
        bus(OFS_PULLUP, 8'hFF, WR);
        bus(OFS_PULLUP, 8'h3F, RD);
        st;
        cmp_pad(pullup_on, 6'h3F);
        bus(OFS_DIRECTION, 8'h00, WR);
        st;
        cmp_pad(pullup_on, 6'h08);
        bus(OFS_PULLUP, 8'h37, WR);
        st;
        cmp_pad(pullup_on, 6'h00);
        @(posedge clk);
        ext_reset_enable <= 1'b1;
        st;
        cmp_pad(pullup_on, 6'h08);
        // Other reset keeps the latch
        bus(OFS_LATCH, 8'h15, WR);
        @(posedge clk);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
        bus(OFS_DIRECTION, 8'h3F, RD);
        bus(OFS_ANALOG, 8'h37, RD);
        bus(OFS_PULLUP, 8'h00, RD);
        bus(OFS_LATCH, 8'h15, RD);
        // Power-on reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(OFS_LATCH, 8'h00, RD);
        bus(OFS_ANALOG, 8'h37, RD);
        repeat (3) @(posedge clk);
        wrap_up;
    end
endmodule
